// ===== rtl/selftest_pkg.sv
package selftest_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned FAIL_WAIT_S    = 15;
  localparam int unsigned FAIL_WAIT_CYC  = FAIL_WAIT_S * CLK_HZ;
  localparam int unsigned REFRESH_S      = 1;
  localparam int unsigned REFRESH_CYC    = REFRESH_S * CLK_HZ;
  localparam int unsigned TIMER_MS       = 498;
  localparam int unsigned TIMER_CYC      = TIMER_MS * (CLK_HZ / 1000);
  localparam int unsigned TIMER_TOL_MS   = 2;
  localparam int unsigned TIMER_TOL_CYC  = TIMER_TOL_MS * (CLK_HZ / 1000);
  localparam int unsigned ACK_GAP_CYC    = 2;

  // ****************************************
  // Memory map seen by the sequencer
  // ****************************************
  localparam int          AW             = 16;
  localparam int unsigned ROM_WORDS      = 4096;
  localparam int unsigned NV_WORDS       = 256;
  localparam int unsigned SA_WORDS       = 8;
  localparam logic [15:0] ROM_BASE       = 16'h0000;
  localparam logic [15:0] TIMER_ACK_ADDR = 16'h4000;
  localparam logic [15:0] NV_BASE        = 16'h8000;
  localparam logic [15:0] NV_SCRATCH     = 16'h8100;
  localparam logic [15:0] NV_CODE_ADDR   = 16'h8101;
  localparam logic [15:0] SA_BASE        = 16'hA000;
  localparam logic [15:0] PKT_BASE       = 16'hC000;
  localparam logic [15:0] ONE16          = 16'h0001;

  // ****************************************
  // Patterns and check constants
  // ****************************************
  localparam logic [31:0] CRC_INIT       = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY       = 32'hEDB88320;
  localparam logic [31:0] PAT_WRITE      = 32'hA5A55A5A;
  localparam logic [31:0] PAT_LOW        = 32'h00000000;
  localparam logic [31:0] PAT_HIGH       = 32'hFFFFFFFF;
  localparam logic [4:0]  RETRY_LIMIT    = 5'h10;

  // ****************************************
  // Register port
  // ****************************************
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_STATUS     = 8'h04;
  localparam logic [7:0]  REG_CODE       = 8'h08;
  localparam logic [7:0]  REG_MFG        = 8'h0C;
  localparam logic [7:0]  REG_PASSES     = 8'h10;
  localparam int          CTRL_RESTART   = 0;

  typedef enum logic [3:0] {
    TS_ROM_CRC, TS_NV_SUM, TS_NV_WRITE, TS_SA_SUM, TS_TIMER,
    TS_REFRESH, TS_RESET_A, TS_RESET_B, TS_TX_CRC, TS_RX_CRC,
    TS_BAD_CRC, TS_COLLIDE, TS_MC_ACCEPT, TS_MC_REJECT, TS_REJECT_UC
  } test_type;

  typedef enum logic [3:0] {
    ST_START, ST_READ, ST_DATA, ST_WRITE, ST_WAIT, ST_TIRQ,
    ST_CTL, ST_CWAIT, ST_NEXT, ST_LOG, ST_HOLD, ST_RUN
  } state_type;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [31:0] wdata;
  } mem_req_type;

  typedef struct packed {
    logic       irq;
    logic [7:0] vec;
    logic [2:0] level;
  } timer_type;

  typedef struct packed {
    logic     start;
    test_type op;
    logic     tx_crc_disable;
    logic     force_collision;
    logic     loopback;
  } ctl_cmd_type;

  typedef struct packed {
    logic        done;
    logic        a_set;
    logic        b_set;
    logic        tx_ok;
    logic        rx_ok;
    logic        crc_err;
    logic        retry_err;
    logic [4:0]  retries;
    logic        stray_irq;
    logic [31:0] crc;
  } ctl_res_type;

endpackage : selftest_pkg

// ===== rtl/bridge_selftest.sv
`timescale 1ns/1ns
// Summary of operation
// - Self-test starts after power-on reset and after a soft restart.
// - A switch picks single-run normal mode or repeating loop mode.
// - Normal mode tests from processor-level checks up to network tests.
// - A clean normal pass lights the pass LED and hands over to run.
// - A normal failure stores the test code in NV memory, LED stays dark.
// - After a normal failure hold fifteen seconds, then rerun self-test.
// - A later failure overwrites the earlier stored code.
// - Loop mode repeats the full sequence until an error or power-off.
// - Loop mode runs the NV write test only on the first pass.
// - Loop mode lights the LED after the first pass while no error.
// - Loop failure clears LED, stores code in NV and manufacturing register.
// - After loop failure repeat only that test, one trigger pulse each time.
// - Program store CRC32 over all but last word, compared with last word.
// - NV and station-address stores use 16-bit rotate-then-add checksums.
// - Timer interrupt: right vector and level, 498 ms, cleared by 4000 read.
// - Refresh: write pattern, wait one second, compare, both bit values.
// - Resetting one controller clears it and leaves the other intact.
// - Generated transmit CRC must equal the precomputed value.
// - Supplied CRC: good one accepted cleanly, corrupted one flagged.
// - Forced collision gives sixteen retries then a retry error.
// - Multicast filter accepts matching frames and drops others.
// - Foreign unicast sends, is not received, raises no stray interrupt.
module bridge_selftest
  import selftest_pkg::*;
#(
  parameter int unsigned FAIL_CYC  = FAIL_WAIT_CYC,
  parameter int unsigned RFSH_CYC  = REFRESH_CYC,
  parameter int unsigned TMR_CYC   = TIMER_CYC,
  parameter int unsigned TMR_TOL   = TIMER_TOL_CYC,
  parameter int unsigned ROM_N     = ROM_WORDS,
  parameter int unsigned NV_N      = NV_WORDS,
  parameter int unsigned SA_N      = SA_WORDS,
  parameter logic [7:0]  TMR_VEC   = 8'h40,
  parameter logic [2:0]  TMR_LEVEL = 3'h6,
  parameter logic [31:0] TX_CRC    = 32'h00000000
) (
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  input  wire logic        loop_mode_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  output mem_req_type      mem_o,
  input  wire logic [31:0] mem_rdata_i,
  input  timer_type        tmr_i,
  output ctl_cmd_type      ctl_o,
  input  ctl_res_type      ctl_i,
  output logic             led_o,
  output logic             run_o,
  output logic             trig_o,
  output logic      [7:0]  mfg_o
);

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);

  state_type   state_r;
  test_type    cur_r;
  logic [15:0] idx_r;
  logic [15:0] addr_r;
  logic [31:0] wdata_r;
  logic [31:0] acc_r;
  logic [31:0] cnt_r;
  logic        ok_r;
  logic        first_r;
  logic        loop_r;
  logic        repeat_r;
  logic        led_r;
  logic        trig_r;
  logic [7:0]  code_r;
  logic [7:0]  mfg_r;
  logic [15:0] passes_r;
  logic [31:0] rdata_r;
  logic        restart;
  logic [15:0] last_idx;
  logic        tmr_good;

  // ****************************************
  // Check helpers
  // ****************************************
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] x;
    x = c;
    for (int i = 0; i < 32; i++) begin
      x = (x[0] ^ d[i]) ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction : crc_step

  function automatic logic [15:0] csum_step(input logic [15:0] s, input logic [15:0] w);
    logic [16:0] t;
    t = {1'b0, s[14:0], s[15]} + {1'b0, w};
    return t[15:0] + {15'h0000, t[16]};
  endfunction : csum_step

  function automatic logic ctl_pass(input test_type t, input ctl_res_type r, input logic [31:0] ref_crc);
    logic p;
    p = 1'b0;
    case (t)
      TS_RESET_A:   p = !r.a_set && r.b_set;
      TS_RESET_B:   p = r.a_set && !r.b_set;
      TS_TX_CRC:    p = r.tx_ok && r.rx_ok && !r.crc_err && (r.crc == ref_crc);
      TS_RX_CRC:    p = r.tx_ok && r.rx_ok && !r.crc_err;
      TS_BAD_CRC:   p = r.tx_ok && r.rx_ok && r.crc_err;
      TS_COLLIDE:   p = r.retry_err && (r.retries == RETRY_LIMIT);
      TS_MC_ACCEPT: p = r.tx_ok && r.rx_ok;
      TS_MC_REJECT: p = r.tx_ok && !r.rx_ok;
      TS_REJECT_UC: p = r.tx_ok && !r.rx_ok && !r.stray_irq;
      default:      p = 1'b0;
    endcase
    return p;
  endfunction : ctl_pass

  // ****************************************
  // Register port
  // ****************************************
  // soft restart request
  assign restart = reg_wr_i && (reg_addr_i == REG_CTRL) && reg_wdata_i[CTRL_RESTART];

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rdata_r <= 32'h00000000;
    end else if (reg_rd_i) begin
      if (reg_addr_i == REG_STATUS) begin
        rdata_r <= {20'h00000, state_r, repeat_r, first_r, loop_r, run_o, led_r, ok_r, 2'h0};
      end else if (reg_addr_i == REG_CODE) begin
        rdata_r <= {24'h000000, code_r};
      end else if (reg_addr_i == REG_MFG) begin
        rdata_r <= {24'h000000, mfg_r};
      end else if (reg_addr_i == REG_PASSES) begin
        rdata_r <= {16'h0000, passes_r};
      end else begin
        rdata_r <= 32'h00000000;
      end
    end else begin
      rdata_r <= 32'h00000000;
    end
  end

  assign reg_rdata_o = rdata_r;

  // ****************************************
  // Outward strobes
  // ****************************************
  always_comb begin
    mem_o.rd    = (state_r == ST_READ);
    mem_o.wr    = (state_r == ST_WRITE) || (state_r == ST_LOG);
    mem_o.addr  = addr_r;
    mem_o.wdata = wdata_r;
    ctl_o.start = (state_r == ST_CTL);
    ctl_o.op    = cur_r;
    ctl_o.tx_crc_disable  = (cur_r == TS_RX_CRC) || (cur_r == TS_BAD_CRC);
    ctl_o.force_collision = (cur_r == TS_COLLIDE);
    ctl_o.loopback        = 1'b1;
  end

  assign led_o  = led_r;
  assign run_o  = (state_r == ST_RUN);
  assign trig_o = trig_r;
  assign mfg_o  = mfg_r;

  always_comb begin
    last_idx = 16'(ROM_N - 1);
    if (cur_r == TS_NV_SUM) begin
      last_idx = 16'(NV_N - 1);
    end else if (cur_r == TS_SA_SUM) begin
      last_idx = 16'(SA_N - 1);
    end
  end

  assign tmr_good = (tmr_i.vec == TMR_VEC) && (tmr_i.level == TMR_LEVEL);

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge clock_i) begin
    trig_r <= 1'b0;
    if (srst_i || restart) begin
      state_r  <= ST_START;
      cur_r    <= TS_ROM_CRC;
      first_r  <= 1'b1;
      repeat_r <= 1'b0;
      led_r    <= 1'b0;
      ok_r     <= 1'b0;
      idx_r    <= 16'h0000;
      addr_r   <= 16'h0000;
      wdata_r  <= 32'h00000000;
      acc_r    <= 32'h00000000;
      cnt_r    <= 32'h00000000;
      loop_r   <= 1'b0;
    end else begin
      case (state_r)
        ST_START: begin
          idx_r <= 16'h0000;
          cnt_r <= 32'h00000000;
          ok_r  <= 1'b0;
          if (!repeat_r && cur_r == TS_ROM_CRC) begin
            loop_r <= loop_mode_i;
          end
          trig_r <= repeat_r;
          case (cur_r)
            TS_ROM_CRC: begin
              acc_r   <= CRC_INIT;
              addr_r  <= ROM_BASE;
              state_r <= ST_READ;
            end
            TS_NV_SUM: begin
              acc_r   <= 32'h00000000;
              addr_r  <= NV_BASE;
              state_r <= ST_READ;
            end
            TS_SA_SUM: begin
              acc_r   <= 32'h00000000;
              addr_r  <= SA_BASE;
              state_r <= ST_READ;
            end
            TS_NV_WRITE: begin
              addr_r  <= NV_SCRATCH;
              wdata_r <= PAT_WRITE;
              state_r <= ST_WRITE;
            end
            TS_REFRESH: begin
              addr_r  <= PKT_BASE;
              wdata_r <= PAT_LOW;
              state_r <= ST_WRITE;
            end
            TS_TIMER: begin
              addr_r  <= TIMER_ACK_ADDR;
              state_r <= ST_TIRQ;
            end
            default: begin
              state_r <= ST_CTL;
            end
          endcase
        end
        ST_WRITE: begin
          cnt_r   <= 32'h00000000;
          state_r <= (cur_r == TS_REFRESH) ? ST_WAIT : ST_READ;
        end
        ST_WAIT: begin
          cnt_r <= cnt_r + 32'h00000001;
          if (cnt_r == RFSH_CYC - 1) begin
            state_r <= ST_READ;
          end
        end
        ST_READ: begin
          state_r <= ST_DATA;
        end
        ST_DATA: begin
          case (cur_r)
            TS_ROM_CRC: begin
              if (idx_r == last_idx) begin
                ok_r    <= (~acc_r == mem_rdata_i);
                state_r <= ST_NEXT;
              end else begin
                acc_r   <= crc_step(acc_r, mem_rdata_i);
                idx_r   <= idx_r + ONE16;
                addr_r  <= addr_r + ONE16;
                state_r <= ST_READ;
              end
            end
            TS_NV_SUM, TS_SA_SUM: begin
              if (idx_r == last_idx) begin
                ok_r    <= (acc_r[15:0] == mem_rdata_i[15:0]);
                state_r <= ST_NEXT;
              end else begin
                acc_r   <= {16'h0000, csum_step(acc_r[15:0], mem_rdata_i[15:0])};
                idx_r   <= idx_r + ONE16;
                addr_r  <= addr_r + ONE16;
                state_r <= ST_READ;
              end
            end
            TS_REFRESH: begin
              if (mem_rdata_i != wdata_r) begin
                ok_r    <= 1'b0;
                state_r <= ST_NEXT;
              end else if (idx_r == 16'h0000) begin
                idx_r   <= ONE16;
                wdata_r <= PAT_HIGH;
                state_r <= ST_WRITE;
              end else begin
                ok_r    <= 1'b1;
                state_r <= ST_NEXT;
              end
            end
            TS_TIMER: begin
              if (tmr_i.irq) begin
                ok_r    <= 1'b0;
                state_r <= ST_NEXT;
              end else if (idx_r == 16'h0000) begin
                idx_r   <= ONE16;
                cnt_r   <= ACK_GAP_CYC;
                state_r <= ST_TIRQ;
              end else begin
                ok_r    <= 1'b1;
                state_r <= ST_NEXT;
              end
            end
            default: begin
              ok_r    <= (mem_rdata_i == wdata_r);
              state_r <= ST_NEXT;
            end
          endcase
        end
        ST_TIRQ: begin
          cnt_r <= cnt_r + 32'h00000001;
          if (tmr_i.irq) begin
            if (!tmr_good || (idx_r != 16'h0000 && cnt_r < TMR_CYC - TMR_TOL)) begin
              ok_r    <= 1'b0;
              state_r <= ST_NEXT;
            end else begin
              state_r <= ST_READ;
            end
          end else if (cnt_r > TMR_CYC + TMR_TOL) begin
            ok_r    <= 1'b0;
            state_r <= ST_NEXT;
          end
        end
        ST_CTL: begin
          state_r <= ST_CWAIT;
        end
        ST_CWAIT: begin
          if (ctl_i.done) begin
            ok_r    <= ctl_pass(cur_r, ctl_i, TX_CRC);
            state_r <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          if (repeat_r) begin
            state_r <= ST_START;
          end else if (!ok_r) begin
            led_r   <= 1'b0;
            addr_r  <= NV_CODE_ADDR;
            wdata_r <= {28'h0000000, cur_r} + 32'h00000001;
            state_r <= ST_LOG;
          end else if (cur_r == TS_REJECT_UC) begin
            led_r   <= 1'b1;
            first_r <= 1'b0;
            cur_r   <= TS_ROM_CRC;
            state_r <= loop_r ? ST_START : ST_RUN;
          end else begin
            if (cur_r == TS_NV_SUM && !first_r) begin
              cur_r <= TS_SA_SUM;
            end else begin
              cur_r <= test_type'(cur_r + 4'h1);
            end
            state_r <= ST_START;
          end
        end
        ST_LOG: begin
          cnt_r <= 32'h00000000;
          if (loop_r) begin
            repeat_r <= 1'b1;
            state_r  <= ST_START;
          end else begin
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          cnt_r <= cnt_r + 32'h00000001;
          if (cnt_r == FAIL_CYC - 1) begin
            cur_r   <= TS_ROM_CRC;
            first_r <= 1'b1;
            state_r <= ST_START;
          end
        end
        default: begin
          state_r <= ST_RUN;
        end
      endcase
    end
  end

  // ****************************************
  // Failure record and pass count
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      code_r   <= 8'h00;
      mfg_r    <= 8'h00;
      passes_r <= 16'h0000;
    end else begin
      if (state_r == ST_LOG) begin
        code_r <= wdata_r[7:0];
        if (loop_r) begin
          mfg_r <= wdata_r[7:0];
        end
      end
      if (state_r == ST_NEXT && ok_r && !repeat_r && cur_r == TS_REJECT_UC) begin
        passes_r <= passes_r + ONE16;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_start_reset: assert property ($past(srst_i) |-> state_r == ST_START)
    else $error("sequence did not start after reset");
  a_run_led: assert property (run_o |-> led_o && !loop_r)
    else $error("run entered without pass LED");
  a_hold_dark: assert property (state_r == ST_HOLD |-> !led_o && code_r == wdata_r[7:0])
    else $error("hold state with LED lit or code missing");
  a_hold_time: assert property ($fell(state_r == ST_HOLD) && !$past(restart)
    |-> $past(cnt_r) == FAIL_CYC - 1 && state_r == ST_START)
    else $error("hold left at wrong count");
  a_code_write: assert property (state_r == ST_LOG |-> mem_o.wr && mem_o.addr == NV_CODE_ADDR
    ##1 code_r == $past(wdata_r[7:0]))
    else $error("failure code not stored");
  a_nv_skip: assert property (state_r == ST_START && cur_r == TS_NV_WRITE |-> first_r)
    else $error("NV write test ran after first pass");
  a_mfg_loop: assert property ($changed(mfg_r) |-> $past(loop_r) && !led_o)
    else $error("manufacturing register written outside loop mode");
  a_trig_repeat: assert property (trig_o |-> repeat_r && $past(state_r == ST_START))
    else $error("trigger pulse outside repeat");
  a_crc_range: assert property (state_r == ST_READ && cur_r == TS_ROM_CRC
    |-> idx_r <= 16'(ROM_N - 1))
    else $error("program store read beyond end");
  a_ack_read: assert property (state_r == ST_READ && cur_r == TS_TIMER
    |-> mem_o.rd && mem_o.addr == TIMER_ACK_ADDR)
    else $error("timer acknowledge not at its address");
  a_collide_cmd: assert property (ctl_o.start && cur_r == TS_COLLIDE
    |-> ctl_o.force_collision && !ctl_o.tx_crc_disable)
    else $error("collision test without forced collision");

  c_normal_pass: cover property (state_r == ST_NEXT ##1 state_r == ST_RUN);
  c_loop_repeat: cover property (trig_o);
  c_hold_exit:   cover property (state_r == ST_HOLD ##1 state_r == ST_START);
  c_loop_second: cover property (loop_r && !first_r && state_r == ST_START && cur_r == TS_SA_SUM);

endmodule : bridge_selftest

// ===== test/selftest_partner.sv
`timescale 1ns/1ns
module selftest_partner
  import selftest_pkg::*;
#(
  parameter int unsigned ROM_N   = 8,
  parameter int unsigned NV_N    = NV_WORDS,
  parameter int unsigned SA_N    = SA_WORDS,
  parameter int          TMR_CYC = 100,
  parameter logic [31:0] TX_CRC  = 32'h00000000
) (
  input  wire logic   clock_i,
  input  mem_req_type mem_i,
  output logic [31:0] mem_rdata_o,
  output timer_type   tmr_o,
  input  ctl_cmd_type ctl_i,
  output ctl_res_type ctl_o,
  input  wire logic   bad_en_i,
  input  test_type    bad_op_i
);
  logic [31:0] mem [int];
  logic [31:0] crc;
  logic [16:0] t;
  logic [15:0] s;
  int          base;
  int          cnt;
  int          tcnt = 0;
  int          dly = 0;
  test_type    op_r;

  // ****************************************
  // Memories, timer and controllers
  // ****************************************
  initial begin
    ctl_o = '0;
    mem_rdata_o = 32'h00000000;
    crc = CRC_INIT;
    for (int i = 0; i < ROM_N; i++) mem[i] = 32'h12345678 * (i + 1);
    for (int i = 0; i < ROM_N - 1; i++)
      for (int b = 0; b < 32; b++) crc = (crc >> 1) ^ ((crc[0] ^ mem[i][b]) ? CRC_POLY : 32'h00000000);
    mem[ROM_N - 1] = ~crc;
    for (int k = 0; k < 2; k++) begin
      base = k ? SA_BASE : NV_BASE;
      cnt = k ? SA_N : NV_N;
      s = 16'h0000;
      for (int i = 0; i < cnt - 1; i++) begin
        mem[base + i] = 32'h00000101 * (i + 2);
        t = {1'b0, s[14:0], s[15]} + mem[base + i][15:0];
        s = t[15:0] + t[16];
      end
      mem[base + cnt - 1] = {16'h0000, s};
    end
  end

  always @(posedge clock_i) begin
    if (mem_i.wr) mem[mem_i.addr] = mem_i.wdata;
    if (mem_i.rd && mem.exists(mem_i.addr)) mem_rdata_o <= mem[mem_i.addr];
    else mem_rdata_o <= ~mem_rdata_o;
    if (mem_i.rd && mem_i.addr == TIMER_ACK_ADDR) tcnt <= 0;
    else if (tcnt < TMR_CYC) tcnt <= tcnt + 1;
  end

  assign tmr_o = {tcnt >= TMR_CYC, 8'h40, 3'h6};

  function automatic ctl_res_type answer(input test_type o);
    ctl_res_type r;
    r = '0;
    r.done = 1'b1;
    if (bad_en_i && o == bad_op_i) return r;
    case (o)
      TS_RESET_A: r.b_set = 1'b1;
      TS_RESET_B: r.a_set = 1'b1;
      TS_TX_CRC: begin
        {r.tx_ok, r.rx_ok} = 2'b11;
        r.crc = TX_CRC;
      end
      TS_RX_CRC, TS_MC_ACCEPT: {r.tx_ok, r.rx_ok} = 2'b11;
      TS_BAD_CRC: {r.tx_ok, r.rx_ok, r.crc_err} = 3'b111;
      TS_COLLIDE: begin
        r.retry_err = 1'b1;
        r.retries = RETRY_LIMIT;
      end
      default: r.tx_ok = 1'b1;
    endcase
    return r;
  endfunction : answer

  always @(posedge clock_i) begin
    ctl_o.done <= 1'b0;
    if (ctl_i.start) begin
      op_r <= ctl_i.op;
      dly <= ctl_i.op[0] ? 5 : 1;
    end else if (dly > 0) begin
      dly <= dly - 1;
      if (dly == 1) ctl_o <= answer(op_r);
    end
  end
endmodule : selftest_partner

// ===== test/tb.sv
`timescale 1ns/1ns
module tb;
  import selftest_pkg::*;
  logic        clock_i = 0, srst_i = 1, loop_mode_i = 0, reg_wr_i = 0, reg_rd_i = 0, bad_en = 0, rd_d = 0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h00000000, reg_rdata_o, mem_rdata_i;
  logic [7:0]  mfg_o;
  logic        led_o, run_o, trig_o;
  mem_req_type mem_o;
  timer_type   tmr_i;
  ctl_cmd_type ctl_o;
  ctl_res_type ctl_i;
  test_type    bad_op = TS_ROM_CRC;
  int          fails = 0, checked = 0, nvw = 0, trigs = 0, starts = 0, n, s0, g0, w0;
  logic [31:0] expq[$];
  test_type    ops[$];

  always #10 clock_i = ~clock_i;

  bridge_selftest #(.FAIL_CYC(50), .RFSH_CYC(20), .TMR_CYC(100), .TMR_TOL(5), .ROM_N(8))
    i_bridge_selftest (.clock_i(clock_i), .srst_i(srst_i), .loop_mode_i(loop_mode_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .mem_o(mem_o),
    .mem_rdata_i(mem_rdata_i), .tmr_i(tmr_i), .ctl_o(ctl_o), .ctl_i(ctl_i), .led_o(led_o), .run_o(run_o),
    .trig_o(trig_o), .mfg_o(mfg_o));
  selftest_partner i_selftest_partner (.clock_i(clock_i), .mem_i(mem_o), .mem_rdata_o(mem_rdata_i),
    .tmr_o(tmr_i), .ctl_i(ctl_o), .ctl_o(ctl_i), .bad_en_i(bad_en), .bad_op_i(bad_op));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", fails, checked);
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic reg_acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    if (wr) reg_wr_i <= 1'b1;
    else reg_rd_i <= 1'b1;
    if (!wr) expq.push_back(d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
  endtask : reg_acc

  task automatic wait_mem(input logic wr, input logic [15:0] a, input int lim);
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (!((wr ? mem_o.wr : mem_o.rd) && mem_o.addr == a) && n < lim);
    if (n >= lim) chk(32'h00000000, 32'h00000001);
  endtask : wait_mem

  always @(posedge clock_i) begin
    rd_d <= reg_rd_i;
    if (mem_o.wr && mem_o.addr == NV_SCRATCH) nvw++;
    if (trig_o) trigs++;
    if (ctl_o.start) begin
      starts++;
      ops.push_back(test_type'(ctl_o.op));
    end
  end

  always @(negedge clock_i) if (rd_d) chk(reg_rdata_o, expq.pop_front());

  initial begin
    #(100000 * 20);
    fails++;
    wrap_up();
  end

  initial begin
    void'($urandom(5));
    repeat (3) @(posedge clock_i);
    srst_i <= 1'b0;
    wait_mem(1'b0, ROM_BASE, 4);
    n = 0;
    while (!run_o && n < 5000) begin
      @(posedge clock_i);
      n++;
    end
    chk({run_o, led_o}, 2'b11);
    chk(ops.size(), 9);
    for (int i = 0; i < 9; i++) chk(ops[i], TS_RESET_A + i);
    reg_acc(1'b0, REG_CODE, 32'h00000000);
    reg_acc(1'b0, 8'h20, 32'h00000000);
    reg_acc(1'b0, REG_PASSES, 32'h00000001);
    bad_en <= 1'b1;
    bad_op <= TS_COLLIDE;
    reg_acc(1'b1, REG_CTRL, 32'h00000001);
    wait_mem(1'b1, NV_CODE_ADDR, 5000);
    chk(mem_o.wdata, 12);
    chk({run_o, led_o}, 2'b00);
    bad_op <= TS_MC_ACCEPT;
    wait_mem(1'b0, ROM_BASE, 100);
    chk(n >= 50 && n <= 56, 1'b1);
    wait_mem(1'b1, NV_CODE_ADDR, 5000);
    chk(mem_o.wdata, 13);
    reg_acc(1'b0, REG_CODE, 32'h0000000D);
    bad_en <= 1'b0;
    loop_mode_i <= 1'b1;
    w0 = nvw;
    reg_acc(1'b1, REG_CTRL, 32'h00000001);
    wait_mem(1'b0, ROM_BASE, 100);
    for (int p = 0; p < 2; p++) begin
      wait_mem(1'b0, ROM_BASE, 5000);
      chk({led_o, 31'(nvw - w0)}, {1'b1, 31'h00000001});
    end
    bad_op <= test_type'(TS_RESET_A + $urandom % 9);
    bad_en <= 1'b1;
    wait_mem(1'b1, NV_CODE_ADDR, 5000);
    chk(mem_o.wdata, bad_op + 1);
    repeat (2) @(posedge clock_i);
    chk({led_o, mfg_o}, {1'b0, 8'(bad_op + 1)});
    ops.delete();
    s0 = starts;
    g0 = trigs;
    n = 0;
    while (starts - s0 < 3 && n < 2000) begin
      @(posedge clock_i);
      n++;
    end
    repeat (2) @(posedge clock_i);
    chk(trigs - g0, 3);
    foreach (ops[i]) chk(ops[i], bad_op);
    reg_acc(1'b0, REG_MFG, 32'(bad_op + 1));
    repeat (2) @(posedge clock_i);
    wrap_up();
  end
endmodule : tb
